// *** src/sbsr_pkg.sv ***
// ----------------------------------------------------------------------------
// Notes on behaviour
// ----------------------------------------------------------------------------
package sbsr_pkg;
    localparam int unsigned SBSR_W        = 8;
    localparam int unsigned SBSR_MASK_W   = 6;
    // status byte bit positions
    localparam int unsigned SBSR_B_READY  = 0;
    localparam int unsigned SBSR_B_PAIR   = 1;
    localparam int unsigned SBSR_B_SYNTAX = 2;
    localparam int unsigned SBSR_B_INTERR = 3;
    localparam int unsigned SBSR_B_FPSRQ  = 4;
    localparam int unsigned SBSR_B_CALBAD = 5;
    localparam int unsigned SBSR_B_RQS    = 6;
    localparam int unsigned SBSR_B_PON    = 7;
    // reset and clear values
    localparam logic [7:0]  SBSR_STAT_RST = 8'h80;
    localparam logic [7:0]  SBSR_MASK_CLR = 8'h00;
    localparam logic [7:0]  SBSR_MASK_PON = 8'h80;
    // bits dropped by a serial poll and by a device clear
    localparam logic [7:0]  SBSR_POLL_CLR = 8'hb4;
    localparam logic [7:0]  SBSR_DCL_CLR  = 8'hbc;
endpackage

// *** src/sbsr_sticky_bit.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// one sticky flag: a set in the cycle of a clear wins
// ----------------------------------------------------------------------------
module sbsr_sticky_bit #(
    parameter logic RST_VAL = 1'b0
) (
    // clock and reset
    input  wire logic i_core_clk,
    input  wire logic i_nrst,
    // control
    input  wire logic i_set,
    input  wire logic i_clr,
    // state
    output logic      o_q
);
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_q <= RST_VAL;
        end else if (i_set) begin
            o_q <= 1'b1;
        end else if (i_clr) begin
            o_q <= 1'b0;
        end
    end
endmodule // sbsr_sticky_bit

// *** src/sbsr_rise_det.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// rising-edge detector over a bus of levels
// ----------------------------------------------------------------------------
module sbsr_rise_det #(
    parameter int unsigned W = 1
) (
    // clock and reset
    input  wire logic         i_core_clk,
    input  wire logic         i_nrst,
    // levels in, one-cycle rises out
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_rise
);
    logic [W-1:0] prev_reg;

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            prev_reg <= '0;
        end else begin
            prev_reg <= i_d;
        end
    end

    assign o_rise = i_d & ~prev_reg;
endmodule // sbsr_rise_det

// *** src/sbsr_status_srq.sv ***
`timescale 1ns/1ps
module sbsr_status_srq
    import sbsr_pkg::*;
(
    // clock and reset
    input  wire logic                          i_core_clk,
    input  wire logic                          i_nrst,
    // measurement and calibration events
    input  wire logic                          i_data_ready,
    input  wire logic                          i_data_accept,
    input  wire logic                          i_pair_bad,
    input  wire logic                          i_pair_good,
    input  wire logic                          i_syntax_err,
    input  wire logic                          i_selftest_fail,
    input  wire logic                          i_adc_fail,
    input  wire logic                          i_reading_done,
    input  wire logic                          i_cal_sum_bad,
    input  wire logic                          i_cal_fail,
    input  wire logic                          i_reset_event,
    // front and rear panel
    input  wire logic                          i_fp_srq_button,
    input  wire logic                          i_pon_srq_switch,
    // loop messages
    input  wire logic                          i_mask_wr,
    input  wire logic [sbsr_pkg::SBSR_MASK_W-1:0] i_mask_code,
    input  wire logic                          i_serial_poll,
    input  wire logic                          i_dev_clear,
    input  wire logic                          i_abort,
    input  wire logic                          i_ctl_offer,
    input  wire logic                          i_remote_set,
    input  wire logic                          i_local_set,
    // status byte and service request
    output logic [sbsr_pkg::SBSR_W-1:0]        o_status_byte,
    output logic                               o_status_valid,
    output logic                               o_srq,
    output logic [sbsr_pkg::SBSR_W-1:0]        o_live_status,
    // loop control state
    output logic                               o_ctl_returned,
    output logic                               o_ctl_decline,
    output logic                               o_remote,
    output logic                               o_ppoll_resp
);
    import sbsr_pkg::*;

    // ------------------------------------------------------------------------
    // condition sources
    // ------------------------------------------------------------------------
    logic [SBSR_W-1:0] stat_w;
    logic [SBSR_W-1:0] set_v;
    logic [SBSR_W-1:0] clr_v;
    logic [SBSR_W-1:0] en_bits;
    logic [SBSR_W-1:0] en_rise;
    logic              ready_rise;
    logic              new_reason;
    logic              any_set;
    logic              rqs_reg;
    logic [SBSR_W-1:0] mask_reg;
    logic              pon_load_reg;

    sbsr_rise_det #(
        .W (1)
    ) u_ready_rise (
        .i_core_clk (i_core_clk),
        .i_nrst     (i_nrst),
        .i_d        (i_data_ready),
        .o_rise     (ready_rise)
    );

    // every source sets its bit whatever the mask holds
    always_comb begin
        set_v                = '0;
        set_v[SBSR_B_READY]  = ready_rise;
        set_v[SBSR_B_PAIR]   = i_pair_bad;
        set_v[SBSR_B_SYNTAX] = i_syntax_err;
        // checksum is judged on each reading, not only at power-up
        set_v[SBSR_B_INTERR] = i_selftest_fail | i_adc_fail
                             | (i_reading_done & i_cal_sum_bad);
        set_v[SBSR_B_FPSRQ]  = i_fp_srq_button;
        set_v[SBSR_B_CALBAD] = i_cal_fail;
        set_v[SBSR_B_PON]    = i_reset_event;
    end

    assign any_set = |set_v;

    // ------------------------------------------------------------------------
    // clearing conditions
    // ------------------------------------------------------------------------
    always_comb begin
        clr_v = '0;
        if (i_serial_poll) begin
            clr_v = clr_v | SBSR_POLL_CLR;
            clr_v[SBSR_B_INTERR] = 1'b1;
        end
        if (i_dev_clear) begin
            clr_v = clr_v | SBSR_DCL_CLR;
        end
        // data ready follows the reading: gone once accepted or withdrawn
        clr_v[SBSR_B_READY] = i_data_accept | ~i_data_ready;
        clr_v[SBSR_B_PAIR]  = i_pair_good;
        clr_v[SBSR_B_RQS]   = 1'b0;
    end

    // ------------------------------------------------------------------------
    // status flags, one sticky cell per condition bit
    // ------------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < SBSR_W; gi++) begin : g_stat
            if (gi == SBSR_B_RQS) begin : g_rqs
                assign stat_w[gi] = rqs_reg;
            end else begin : g_cell
                sbsr_sticky_bit #(
                    .RST_VAL (SBSR_STAT_RST[gi])
                ) u_bit (
                    .i_core_clk (i_core_clk),
                    .i_nrst     (i_nrst),
                    .i_set      (set_v[gi]),
                    .i_clr      (clr_v[gi]),
                    .o_q        (stat_w[gi])
                );
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // request-service bit and mask
    // ------------------------------------------------------------------------
    // bit 6 itself never enables itself; bit 7 uses the switch-fed mask bit
    always_comb begin
        en_bits             = stat_w & mask_reg;
        en_bits[SBSR_B_RQS] = 1'b0;
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rqs_reg <= 1'b0;
        end else begin
            rqs_reg <= |en_bits;
        end
    end

    // power-on reset: the switch is sampled in the first cycle after release
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pon_load_reg <= 1'b1;
        end else begin
            pon_load_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            mask_reg <= SBSR_MASK_CLR;
        end else if (i_dev_clear) begin
            mask_reg <= i_pon_srq_switch ? SBSR_MASK_PON : SBSR_MASK_CLR;
        end else if (pon_load_reg) begin
            mask_reg[SBSR_B_PON] <= i_pon_srq_switch;
        end else if (i_mask_wr) begin
            // only bits 0..5 are programmable; bit 7 stays with the switch
            mask_reg[SBSR_MASK_W-1:0] <= i_mask_code;
        end
    end

    // ------------------------------------------------------------------------
    // service request on the loop
    // ------------------------------------------------------------------------
    sbsr_rise_det #(
        .W (SBSR_W)
    ) u_en_rise (
        .i_core_clk (i_core_clk),
        .i_nrst     (i_nrst),
        .i_d        (en_bits),
        .o_rise     (en_rise)
    );

    assign new_reason = |en_rise;

    // a new reason in the poll cycle wins, so no request is lost
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_srq <= 1'b0;
        end else if (new_reason) begin
            o_srq <= 1'b1;
        end else if (i_serial_poll || !(|en_bits)) begin
            o_srq <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // serial poll answer and loop control
    // ------------------------------------------------------------------------
    // the byte sent is the state before the poll's own clearing
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_status_byte  <= '0;
            o_status_valid <= 1'b0;
        end else begin
            o_status_valid <= i_serial_poll & ~i_abort;
            if (i_serial_poll) begin
                o_status_byte <= stat_w;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_live_status <= SBSR_STAT_RST;
        end else begin
            o_live_status <= stat_w;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_ctl_returned <= 1'b0;
            o_ctl_decline  <= 1'b0;
        end else begin
            o_ctl_returned <= i_abort;
            o_ctl_decline  <= i_ctl_offer;
        end
    end

    // abort leaves remote alone on purpose
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_remote <= 1'b0;
        end else if (i_local_set) begin
            o_remote <= 1'b0;
        end else if (i_remote_set) begin
            o_remote <= 1'b1;
        end
    end

    // parallel poll is not supported, so its bit never asserts
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_ppoll_resp <= 1'b0;
        end else begin
            o_ppoll_resp <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    property p_mask_no_set;
        @(posedge i_core_clk) disable iff (!i_nrst)
        (i_mask_wr && !any_set) |=> ((stat_w & ~$past(stat_w) & ~(8'h01 << SBSR_B_RQS)) == 8'h00);
    endproperty
    a_mask_no_set: assert property (p_mask_no_set) else $error("mask write set a status bit");

    property p_syntax_sets;
        @(posedge i_core_clk) disable iff (!i_nrst)
        i_syntax_err |=> stat_w[SBSR_B_SYNTAX];
    endproperty
    a_syntax_sets: assert property (p_syntax_sets) else $error("syntax error bit not set");

    property p_unmasked_quiet;
        @(posedge i_core_clk) disable iff (!i_nrst)
        (en_bits == 8'h00) |=> !o_srq;
    endproperty
    a_unmasked_quiet: assert property (p_unmasked_quiet) else $error("request with nothing enabled");

    property p_rqs_follows;
        @(posedge i_core_clk) disable iff (!i_nrst)
        i_serial_poll ##1 1'b1 |-> o_status_byte[SBSR_B_RQS] == $past(|en_bits, 2);
    endproperty
    a_rqs_follows: assert property (p_rqs_follows) else $error("polled bit 6 wrong");

    property p_srq_on_reason;
        @(posedge i_core_clk) disable iff (!i_nrst)
        new_reason |=> o_srq && rqs_reg;
    endproperty
    a_srq_on_reason: assert property (p_srq_on_reason) else $error("new reason sent no request");

    property p_poll_drops_srq;
        @(posedge i_core_clk) disable iff (!i_nrst)
        (i_serial_poll && !new_reason) |=> !o_srq;
    endproperty
    a_poll_drops_srq: assert property (p_poll_drops_srq) else $error("poll left request set");

    property p_poll_clears;
        @(posedge i_core_clk) disable iff (!i_nrst)
        (i_serial_poll && !any_set) |=> !stat_w[SBSR_B_SYNTAX] && !stat_w[SBSR_B_FPSRQ]
                                        && !stat_w[SBSR_B_CALBAD] && !stat_w[SBSR_B_PON];
    endproperty
    a_poll_clears: assert property (p_poll_clears) else $error("poll did not clear bits");

    property p_ready_clears;
        @(posedge i_core_clk) disable iff (!i_nrst)
        (i_data_accept && !ready_rise) |=> !stat_w[SBSR_B_READY];
    endproperty
    a_ready_clears: assert property (p_ready_clears) else $error("data ready stuck");

    sequence s_poll_req;
        i_serial_poll && !i_abort;
    endsequence
    sequence s_poll_ans;
        o_status_valid ##1 !o_status_valid;
    endsequence
    property p_poll_answer;
        @(posedge i_core_clk) disable iff (!i_nrst)
        s_poll_req ##1 !i_serial_poll |-> s_poll_ans;
    endproperty
    a_poll_answer: assert property (p_poll_answer) else $error("poll answer not one pulse");

    property p_abort_keeps;
        @(posedge i_core_clk) disable iff (!i_nrst)
        (i_abort && !i_local_set && !i_remote_set) |=> o_ctl_returned && (o_remote == $past(o_remote));
    endproperty
    a_abort_keeps: assert property (p_abort_keeps) else $error("abort changed remote");

    property p_dcl_mask;
        @(posedge i_core_clk) disable iff (!i_nrst)
        i_dev_clear |=> mask_reg == ($past(i_pon_srq_switch) ? SBSR_MASK_PON : SBSR_MASK_CLR);
    endproperty
    a_dcl_mask: assert property (p_dcl_mask) else $error("device clear mask wrong");

    property p_decline;
        @(posedge i_core_clk) disable iff (!i_nrst)
        i_ctl_offer |=> o_ctl_decline;
    endproperty
    a_decline: assert property (p_decline) else $error("control offer not declined");

    property p_pair_clears;
        @(posedge i_core_clk) disable iff (!i_nrst)
        (i_pair_good && !i_pair_bad) |=> !stat_w[SBSR_B_PAIR];
    endproperty
    a_pair_clears: assert property (p_pair_clears) else $error("pair bit not cleared");

    property p_sum_sets;
        @(posedge i_core_clk) disable iff (!i_nrst)
        (i_reading_done && i_cal_sum_bad) |=> stat_w[SBSR_B_INTERR];
    endproperty
    a_sum_sets: assert property (p_sum_sets) else $error("checksum failure not flagged");

    property p_pon_mask;
        @(posedge i_core_clk) disable iff (!i_nrst)
        (pon_load_reg && !i_dev_clear) |=> mask_reg[SBSR_B_PON] == $past(i_pon_srq_switch);
    endproperty
    a_pon_mask: assert property (p_pon_mask) else $error("switch not loaded into mask");

    property p_srq_needs_rqs;
        @(posedge i_core_clk) disable iff (!i_nrst)
        o_srq |-> rqs_reg;
    endproperty
    a_srq_needs_rqs: assert property (p_srq_needs_rqs) else $error("request without bit 6");
endmodule // sbsr_status_srq

// *** test/sbsr_loop_ctl.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// loop controller model: one message pulse at a time
// ----------------------------------------------------------------------------
module sbsr_loop_ctl
    import sbsr_pkg::*;
(
    // clock
    input  wire logic                             i_core_clk,
    // answer to a poll
    input  wire logic                             i_status_valid,
    input  wire logic [sbsr_pkg::SBSR_W-1:0]      i_status_byte,
    // loop messages
    output logic                                  o_mask_wr,
    output logic [sbsr_pkg::SBSR_MASK_W-1:0]      o_mask_code,
    output logic [5:0]                            o_msg,
    // last polled byte
    output logic [sbsr_pkg::SBSR_W-1:0]           o_polled
);
    initial begin
        o_mask_wr = 1'b0;
        o_mask_code = 6'h00;
        o_msg = 6'h00;
        o_polled = 8'h00;
    end
    // k 0 poll, 1 clear, 2 abort, 3 offer, 4 remote, 5 local, 6 mask, 7 poll with abort
    task automatic send(input int k, input logic [5:0] c);
        @(posedge i_core_clk);
        if (k == 6) begin
            o_mask_wr <= 1'b1;
            o_mask_code <= c;
        end else if (k == 7) begin
            o_msg <= 6'h05;
        end else begin
            o_msg <= 6'(1 << k);
        end
        @(posedge i_core_clk);
        o_mask_wr <= 1'b0;
        o_msg <= 6'h00;
        // a released code field must not look like a fresh one
        o_mask_code <= ~c;
    endtask
    always @(posedge i_core_clk) begin
        if (i_status_valid === 1'b1) begin
            o_polled <= i_status_byte;
        end
    end
endmodule // sbsr_loop_ctl

// *** test/tb_sbsr_status_srq.sv ***
`timescale 1ns/1ps
module tb_sbsr_status_srq;
    import sbsr_pkg::*;
    // ----------------------------------------------------------------------------
    // stimulus and expected state
    // ----------------------------------------------------------------------------
    logic        i_core_clk = 1'b0;
    logic        i_nrst     = 1'b0;
    logic        rdy        = 1'b0;
    logic        sw         = 1'b0;
    logic [11:0] pul        = 12'h000;
    logic [7:0]  e_stat, e_mask, stb, live, pol;
    logic        e_srq, srq, vld, ret, dec, rmt, ppr, mwr;
    logic [5:0]  mcd, msg;
    int          errors     = 0;
    int          checked    = 0;
    int          cyc        = 0;
    int          r;
    localparam logic [7:0] SETS [12] = '{8'h00, 8'h00, 8'h02, 8'h00, 8'h04, 8'h10,
                                         8'h20, 8'h80, 8'h08, 8'h08, 8'h08, 8'h00};
    localparam logic [7:0] CLRS [12] = '{8'h00, 8'h01, 8'h00, 8'h02, 8'h00, 8'h00,
                                         8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    always #25 i_core_clk = ~i_core_clk;
    sbsr_status_srq u_sbsr_status_srq (
        .i_core_clk(i_core_clk), .i_nrst(i_nrst),
        .i_data_ready(rdy), .i_data_accept(pul[1]), .i_pair_bad(pul[2]),
        .i_pair_good(pul[3]), .i_syntax_err(pul[4]), .i_fp_srq_button(pul[5]),
        .i_cal_fail(pul[6]), .i_reset_event(pul[7]), .i_selftest_fail(pul[8]),
        .i_adc_fail(pul[9]), .i_cal_sum_bad(pul[10]), .i_reading_done(pul[11]),
        .i_pon_srq_switch(sw), .i_mask_wr(mwr), .i_mask_code(mcd),
        .i_serial_poll(msg[0]), .i_dev_clear(msg[1]), .i_abort(msg[2]),
        .i_ctl_offer(msg[3]), .i_remote_set(msg[4]), .i_local_set(msg[5]),
        .o_status_byte(stb), .o_status_valid(vld), .o_srq(srq),
        .o_live_status(live), .o_ctl_returned(ret), .o_ctl_decline(dec),
        .o_remote(rmt), .o_ppoll_resp(ppr)
    );
    sbsr_loop_ctl u_sbsr_loop_ctl (
        .i_core_clk(i_core_clk), .i_status_valid(vld), .i_status_byte(stb),
        .o_mask_wr(mwr), .o_mask_code(mcd), .o_msg(msg), .o_polled(pol)
    );
    // ----------------------------------------------------------------------------
    // checking helpers
    // ----------------------------------------------------------------------------
    task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_bit(input string n, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %b seen %b", n, e, g);
        end
    endtask
    function automatic logic [7:0] en_bits();
        en_bits = e_stat & e_mask & 8'hbf;
    endfunction
    function automatic logic [7:0] exp_live();
        exp_live = e_stat & 8'hbf;
        exp_live[6] = |en_bits();
    endfunction
    // a request rises only on a fresh enabled bit, drops once none is left
    task automatic upd(input logic [7:0] old);
        if (|(en_bits() & ~old))
            e_srq = 1'b1;
        if (en_bits() == 8'h00)
            e_srq = 1'b0;
    endtask
    task automatic settle();
        repeat (4) @(posedge i_core_clk);
        @(negedge i_core_clk);
        chk_byte("live", exp_live(), live);
        chk_bit("srq", e_srq, srq);
        chk_bit("ppoll", 1'b0, ppr);
    endtask
    task automatic ev(input int k);
        logic [7:0] old;
        old = en_bits();
        @(posedge i_core_clk);
        if (k == 0) begin
            rdy <= ~rdy;
            e_stat[0] = ~rdy;
        end
        pul <= (k == 10) ? 12'hc00 : 12'(1 << k);
        e_stat = (e_stat | SETS[k]) & ~CLRS[k];
        @(posedge i_core_clk);
        pul <= 12'h000;
        upd(old);
        settle();
    endtask
    task automatic mask(input logic [5:0] c);
        logic [7:0] old;
        old = en_bits();
        u_sbsr_loop_ctl.send(6, c);
        e_mask[5:0] = c;
        upd(old);
        settle();
    endtask
    task automatic dclr();
        u_sbsr_loop_ctl.send(1, 6'h00);
        e_mask = {sw, 7'h00};
        e_stat = e_stat & ~8'hbc;
        upd(8'h00);
        settle();
    endtask
    task automatic poll();
        logic [7:0] exp;
        exp = exp_live();
        u_sbsr_loop_ctl.send(0, 6'h00);
        @(negedge i_core_clk);
        chk_bit("valid", 1'b1, vld);
        chk_byte("byte", exp, stb);
        // the poll also drops the internal error bit, which has no clear of its own
        e_stat = e_stat & ~8'hbc;
        e_srq = 1'b0;
        @(negedge i_core_clk);
        chk_byte("polled", exp, pol);
        settle();
    endtask
    task automatic results();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge i_core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            results();
        end
    end
    // ----------------------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------------------
    initial begin
        r = $urandom(32'h0c37);
        e_stat = 8'h80;
        e_mask = 8'h00;
        e_srq = 1'b0;
        repeat (4) @(posedge i_core_clk);
        i_nrst <= 1'b1;
        @(negedge i_core_clk);
        chk_byte("live", 8'h80, live);
        chk_bit("valid", 1'b0, vld);
        repeat (2) @(posedge i_core_clk);
        ev(4);
        mask(6'h04);
        ev(0);
        mask(6'h05);
        poll();
        ev(0);
        mask(6'h3f);
        ev(2);
        ev(3);
        ev(1);
        mask(6'h00);
        for (int i = 0; i < 90; i++) begin
            r = $urandom_range(9);
            if (r < 8)
                ev(r);
            else if (r == 8)
                mask(6'($urandom()));
            else
                poll();
        end
        for (int k = 8; k < 12; k++) begin
            mask(6'h08);
            ev(k);
            if (k == 9)
                poll();
            dclr();
        end
        @(posedge i_core_clk);
        sw <= 1'b1;
        dclr();
        ev(7);
        poll();
        u_sbsr_loop_ctl.send(4, 6'h00);
        u_sbsr_loop_ctl.send(2, 6'h00);
        @(negedge i_core_clk);
        chk_bit("returned", 1'b1, ret);
        chk_bit("remote", 1'b1, rmt);
        u_sbsr_loop_ctl.send(7, 6'h00);
        @(negedge i_core_clk);
        chk_bit("valid", 1'b0, vld);
        chk_bit("returned", 1'b1, ret);
        e_stat = e_stat & ~8'hbc;
        e_srq = 1'b0;
        settle();
        u_sbsr_loop_ctl.send(3, 6'h00);
        @(negedge i_core_clk);
        chk_bit("decline", 1'b1, dec);
        u_sbsr_loop_ctl.send(5, 6'h00);
        @(negedge i_core_clk);
        chk_bit("remote", 1'b0, rmt);
        // mid-run reset with the switch on: bit 7 is enabled and raises a request
        @(posedge i_core_clk);
        i_nrst <= 1'b0;
        repeat (4) @(posedge i_core_clk);
        i_nrst <= 1'b1;
        @(negedge i_core_clk);
        chk_bit("srq", 1'b0, srq);
        chk_bit("valid", 1'b0, vld);
        e_stat = {1'b1, 6'h00, rdy};
        e_mask = 8'h80;
        e_srq = 1'b1;
        settle();
        results();
    end
endmodule // tb_sbsr_status_srq
